//--- fdc_cfg_pkg.sv
/*
 Constants for the floppy controller configuration register bank: register indices,
 reset values and field positions. Assumes a byte-wide configuration index/data access.
*/
package fdc_cfg_pkg;
  localparam logic [7:0] IDX_MODE = 8'hf0;
  localparam logic [7:0] IDX_OPTION = 8'hf1;
  localparam logic [7:0] IDX_TYPE = 8'hf2;
  localparam logic [7:0] IDX_RSVD = 8'hf3;
  localparam logic [7:0] IDX_DRIVE0 = 8'hf4;
  localparam logic [7:0] IDX_DRIVE1 = 8'hf5;
  localparam logic [7:0] RST_MODE = 8'h0e;
  localparam logic [7:0] RST_OPTION = 8'h00;
  localparam logic [7:0] RST_TYPE = 8'hff;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  // Writable bits of a per-drive register; bits 2, 5 and 7 stay zero.
  localparam logic [7:0] DRIVE_WMASK = 8'h5b;
  localparam int MODE_ENH = 0;
  localparam int MODE_NONBURST = 1;
  localparam int MODE_IF_LO = 2;
  localparam int MODE_PUSHPULL = 6;
  localparam int MODE_OUTOFF = 7;
  localparam int OPT_FORCE_WP = 0;
  localparam int OPT_DENS_LO = 2;
  localparam int DRV_TYPE_LO = 0;
  localparam int DRV_RATE_LO = 3;
  localparam int DRV_PRECOMP = 6;
  localparam logic [1:0] DENS_FORCE1 = 2'h2;
  localparam logic [1:0] DENS_FORCE0 = 2'h3;
  localparam logic [1:0] IF_AT = 2'h3;
  localparam logic [1:0] IF_ALT2 = 2'h1;
  localparam logic [1:0] IF_ALT3 = 2'h0;
endpackage : fdc_cfg_pkg

//--- floppy_ctrl_config_regs.sv
/*
 Configuration register bank for the floppy controller logical device, with the
 write-protect, density, output-enable and per-drive setting logic it steers.
 Assumes a decoded configuration index/data port delivers one-cycle read and write
 strobes, and that rst is the power-on or hard bus reset only.
*/
// Overview of operation
// - Soft reset leaves every register of this bank unchanged.
// - Defaults return only on power-on or hard bus reset.
// - Mode register 0xF0 resets to 0x0E; bit 0 selects enhanced mode.
// - Mode bit 1: 0 burst DMA, 1 non-burst DMA (default).
// - Mode bits 3:2 pick interface flavour; 11 AT, 10 reserved.
// - Mode bit 6: 0 open-drain outputs, 1 push-pull outputs.
// - Mode bit 7 set puts all drive-side outputs in high impedance.
// - Bits 6 and 7 do not touch floppy signals on parallel pins.
// - Option 0xF1 bit 0 forces write protect when either drive selected.
// - Core write protect ORs forced selects, external input and disable bit.
// - Forced write protect also applies on the parallel port route.
// - Option bits 3:2: 0x normal, 10 force density 1, 11 force 0.
// - Type register 0xF2 resets 0xFF; A in 1:0, B in 3:2.
// - Index 0xF3 is read-only and always reads zero.
// - Drive-0 register 0xF4 resets 0x00; type 1:0, rate table 4:3.
// - Per-drive bit 6 set disables write precompensation for that drive.
// - Drive-1 register 0xF5 matches drive-0 layout and default.
// - Drive 0 is always the boot drive.
module floppy_ctrl_config_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire logic softRst,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgIndex,
  input wire logic [7:0] cfgWdata,
  output logic [7:0] cfgRdata,
  output logic cfgHit,
  input wire logic drive0_select_n,
  input wire logic drive1_select_n,
  input wire logic write_protect_in_n,
  input wire logic floppyWpDisable,
  input wire logic parallelRoute,
  input wire logic coreDensity,
  input wire logic coreOutEnable,
  output logic coreWriteProtect,
  output logic densityOut,
  output logic driveOutEnable,
  output logic parallelOutEnable,
  output logic pushPull,
  output logic enhanced_os_mode,
  output logic nonBurstDma,
  output logic [1:0] interfaceMode,
  output logic [1:0] drive_type_sel,
  output logic [1:0] rate_table_sel,
  output logic precomp_disable,
  output logic bootDrive
);
  logic [7:0] floppyModeControl;
  logic [7:0] floppyOptionControl;
  logic [7:0] driveTypeStore;
  logic [7:0] drive0Settings;
  logic [7:0] drive1Settings;
  logic [7:0] next_floppyModeControl;
  logic [7:0] next_floppyOptionControl;
  logic [7:0] next_driveTypeStore;
  logic [7:0] next_drive0Settings;
  logic [7:0] next_drive1Settings;
  logic [7:0] next_cfgRdata;
  logic [7:0] selSettings;
  logic forcedWp;
  logic [1:0] densSel;

  // softRst is deliberately not used: this bank survives soft resets.
  always_comb begin
    next_floppyModeControl = floppyModeControl;
    next_floppyOptionControl = floppyOptionControl;
    next_driveTypeStore = driveTypeStore;
    next_drive0Settings = drive0Settings;
    next_drive1Settings = drive1Settings;
    if (cfgWrite) begin
      case (cfgIndex)
        fdc_cfg_pkg::IDX_MODE: next_floppyModeControl = cfgWdata;
        fdc_cfg_pkg::IDX_OPTION: next_floppyOptionControl = cfgWdata;
        fdc_cfg_pkg::IDX_TYPE: next_driveTypeStore = cfgWdata;
        fdc_cfg_pkg::IDX_DRIVE0: next_drive0Settings = cfgWdata & fdc_cfg_pkg::DRIVE_WMASK;
        fdc_cfg_pkg::IDX_DRIVE1: next_drive1Settings = cfgWdata & fdc_cfg_pkg::DRIVE_WMASK;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      floppyModeControl <= fdc_cfg_pkg::RST_MODE;
      floppyOptionControl <= fdc_cfg_pkg::RST_OPTION;
      driveTypeStore <= fdc_cfg_pkg::RST_TYPE;
      drive0Settings <= fdc_cfg_pkg::RST_DRIVE;
      drive1Settings <= fdc_cfg_pkg::RST_DRIVE;
    end else begin
      floppyModeControl <= next_floppyModeControl;
      floppyOptionControl <= next_floppyOptionControl;
      driveTypeStore <= next_driveTypeStore;
      drive0Settings <= next_drive0Settings;
      drive1Settings <= next_drive1Settings;
    end
  end

  // Read data is registered so it is stable for the whole data phase.
  always_comb begin
    next_cfgRdata = cfgRdata;
    if (cfgRead) begin
      case (cfgIndex)
        fdc_cfg_pkg::IDX_MODE: next_cfgRdata = floppyModeControl;
        fdc_cfg_pkg::IDX_OPTION: next_cfgRdata = floppyOptionControl;
        fdc_cfg_pkg::IDX_TYPE: next_cfgRdata = driveTypeStore;
        fdc_cfg_pkg::IDX_RSVD: next_cfgRdata = 8'h00;
        fdc_cfg_pkg::IDX_DRIVE0: next_cfgRdata = drive0Settings;
        fdc_cfg_pkg::IDX_DRIVE1: next_cfgRdata = drive1Settings;
        default: next_cfgRdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfgRdata <= 8'h00;
    end else begin
      cfgRdata <= next_cfgRdata;
    end
  end

  assign cfgHit = (cfgIndex >= fdc_cfg_pkg::IDX_MODE) && (cfgIndex <= fdc_cfg_pkg::IDX_DRIVE1);

  // Select lines are active low, so the force term uses the asserted select.
  assign forcedWp = floppyOptionControl[fdc_cfg_pkg::OPT_FORCE_WP]
    & (~drive0_select_n | ~drive1_select_n);
  // Applied regardless of parallelRoute.
  assign coreWriteProtect = forcedWp | ~write_protect_in_n | floppyWpDisable;

  assign densSel = floppyOptionControl[fdc_cfg_pkg::OPT_DENS_LO +: 2];
  always_comb begin
    case (densSel)
      fdc_cfg_pkg::DENS_FORCE1: densityOut = 1'b1;
      fdc_cfg_pkg::DENS_FORCE0: densityOut = 1'b0;
      default: densityOut = coreDensity;
    endcase
  end

  // Open-drain drivers only enable when pulling low; push-pull drives always.
  assign pushPull = floppyModeControl[fdc_cfg_pkg::MODE_PUSHPULL] & ~parallelRoute;
  assign driveOutEnable = ~parallelRoute & coreOutEnable
    & ~floppyModeControl[fdc_cfg_pkg::MODE_OUTOFF];
  // Parallel-port route ignores mode bits 6 and 7.
  assign parallelOutEnable = parallelRoute & coreOutEnable;

  assign enhanced_os_mode = floppyModeControl[fdc_cfg_pkg::MODE_ENH];
  assign nonBurstDma = floppyModeControl[fdc_cfg_pkg::MODE_NONBURST];
  // 2'b10 is reserved; it is passed through unchanged for the core to treat as AT.
  assign interfaceMode = floppyModeControl[fdc_cfg_pkg::MODE_IF_LO +: 2];

  // Drive 1 settings only when drive 1 alone is selected; drive 0 otherwise.
  assign selSettings = (!drive1_select_n && drive0_select_n) ? drive1Settings : drive0Settings;
  assign drive_type_sel = selSettings[fdc_cfg_pkg::DRV_TYPE_LO +: 2];
  assign rate_table_sel = selSettings[fdc_cfg_pkg::DRV_RATE_LO +: 2];
  assign precomp_disable = selSettings[fdc_cfg_pkg::DRV_PRECOMP];
  assign bootDrive = 1'b0;

  a_soft_reset_hold: assert property (@(posedge mclk) disable iff (rst)
    (softRst && !cfgWrite) |=> $stable(floppyModeControl) && $stable(drive0Settings))
    else $error("Soft reset changed a configuration register.");
  a_reset_defaults: assert property (@(posedge mclk)
    rst |=> floppyModeControl == 8'h0e && driveTypeStore == 8'hff && drive1Settings == 8'h00)
    else $error("Registers not at defaults after reset.");
  a_mode_write: assert property (@(posedge mclk) disable iff (rst)
    (cfgWrite && cfgIndex == 8'hf0) |=> floppyModeControl == $past(cfgWdata))
    else $error("Mode register write lost.");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
    (cfgRead && cfgIndex == 8'hf3) |=> cfgRdata == 8'h00)
    else $error("Reserved index read nonzero.");
  a_drive_ro_bits: assert property (@(posedge mclk) disable iff (rst)
    (drive0Settings[2] | drive0Settings[5] | drive0Settings[7]
     | drive1Settings[2] | drive1Settings[5] | drive1Settings[7]) == 1'b0)
    else $error("Read-only per-drive bit set.");
  a_force_wp: assert property (@(posedge mclk) disable iff (rst)
    (floppyOptionControl[0] && !drive0_select_n) |-> coreWriteProtect)
    else $error("Forced write protect not applied.");
  a_wp_or: assert property (@(posedge mclk) disable iff (rst)
    coreWriteProtect == ((floppyOptionControl[0] && (!drive0_select_n || !drive1_select_n))
      || !write_protect_in_n || floppyWpDisable))
    else $error("Write protect equation wrong.");
  a_density_force: assert property (@(posedge mclk) disable iff (rst)
    (floppyOptionControl[3:2] == 2'h3) |-> !densityOut)
    else $error("Density not forced low.");
  a_tristate: assert property (@(posedge mclk) disable iff (rst)
    (floppyModeControl[7] && !parallelRoute) |-> !driveOutEnable)
    else $error("Drive outputs enabled while disabled.");
  a_parallel_free: assert property (@(posedge mclk) disable iff (rst)
    parallelRoute |-> parallelOutEnable == coreOutEnable)
    else $error("Mode bits affected parallel route.");
  a_drive1_pick: assert property (@(posedge mclk) disable iff (rst)
    (!drive1_select_n && drive0_select_n) |-> precomp_disable == drive1Settings[6])
    else $error("Drive 1 settings not presented.");

  // Each access is a one-cycle strobe with its index; the checks below are built from these.
  sequence s_wr_option;
    cfgWrite && cfgIndex == fdc_cfg_pkg::IDX_OPTION;
  endsequence

  sequence s_wr_type;
    cfgWrite && cfgIndex == fdc_cfg_pkg::IDX_TYPE;
  endsequence

  sequence s_wr_drive0;
    cfgWrite && cfgIndex == fdc_cfg_pkg::IDX_DRIVE0;
  endsequence

  sequence s_wr_drive1;
    cfgWrite && cfgIndex == fdc_cfg_pkg::IDX_DRIVE1;
  endsequence

  sequence s_rd_mode;
    cfgRead && cfgIndex == fdc_cfg_pkg::IDX_MODE;
  endsequence

  sequence s_rd_drive1;
    cfgRead && cfgIndex == fdc_cfg_pkg::IDX_DRIVE1;
  endsequence

  sequence s_rd_unmapped;
    cfgRead && !cfgHit;
  endsequence

  a_option_write: assert property (@(posedge mclk) disable iff (rst)
    s_wr_option |=> floppyOptionControl == $past(cfgWdata))
    else $error("Option register write lost.");

  a_type_write: assert property (@(posedge mclk) disable iff (rst)
    s_wr_type |=> driveTypeStore == $past(cfgWdata))
    else $error("Drive type register write lost.");

  a_drive0_write: assert property (@(posedge mclk) disable iff (rst)
    s_wr_drive0 |=> drive0Settings == ($past(cfgWdata) & 8'h5b))
    else $error("Drive 0 register write not masked correctly.");

  a_drive1_write: assert property (@(posedge mclk) disable iff (rst)
    s_wr_drive1 |=> drive1Settings == ($past(cfgWdata) & 8'h5b))
    else $error("Drive 1 register write not masked correctly.");

  a_read_mode: assert property (@(posedge mclk) disable iff (rst)
    s_rd_mode |=> cfgRdata == $past(floppyModeControl))
    else $error("Mode register read wrong.");

  a_read_drive1: assert property (@(posedge mclk) disable iff (rst)
    s_rd_drive1 |=> cfgRdata == $past(drive1Settings))
    else $error("Drive 1 register read wrong.");

  a_unmapped_read: assert property (@(posedge mclk) disable iff (rst)
    s_rd_unmapped |=> cfgRdata == 8'h00)
    else $error("Unmapped index read nonzero.");

  a_soft_reset_all: assert property (@(posedge mclk) disable iff (rst)
    (softRst && !cfgWrite) |=> $stable(floppyOptionControl) && $stable(driveTypeStore)
      && $stable(drive1Settings))
    else $error("Soft reset changed a configuration register.");

  a_option_reset: assert property (@(posedge mclk)
    rst |=> floppyOptionControl == 8'h00 && drive0Settings == 8'h00)
    else $error("Option or drive 0 register not at default after reset.");

  // Defaults seen on the decoded mode outputs, not just inside the register.
  a_mode_defaults: assert property (@(posedge mclk)
    rst |=> nonBurstDma && interfaceMode == 2'h3 && !enhanced_os_mode)
    else $error("Mode outputs not at defaults after reset.");

  a_density_force1: assert property (@(posedge mclk) disable iff (rst)
    (floppyOptionControl[3:2] == 2'h2) |-> densityOut)
    else $error("Density not forced high.");

  a_density_normal: assert property (@(posedge mclk) disable iff (rst)
    !floppyOptionControl[3] |-> densityOut == coreDensity)
    else $error("Density not passed through in normal mode.");

  a_pushpull_mode: assert property (@(posedge mclk) disable iff (rst)
    !parallelRoute |-> pushPull == floppyModeControl[6])
    else $error("Output style does not follow mode bit 6.");

  a_pushpull_parallel: assert property (@(posedge mclk) disable iff (rst)
    parallelRoute |-> !pushPull)
    else $error("Mode bit 6 reached the parallel route.");

  a_wp_parallel: assert property (@(posedge mclk) disable iff (rst)
    (floppyOptionControl[0] && parallelRoute && !drive1_select_n) |-> coreWriteProtect)
    else $error("Forced write protect missing on parallel route.");

  a_drive0_pick: assert property (@(posedge mclk) disable iff (rst)
    !drive0_select_n |-> drive_type_sel == drive0Settings[1:0]
      && rate_table_sel == drive0Settings[4:3])
    else $error("Drive 0 settings not presented.");

  a_boot_drive: assert property (@(posedge mclk) disable iff (rst)
    !bootDrive)
    else $error("Boot drive is not drive 0.");
endmodule : floppy_ctrl_config_regs

//--- testbench.sv
/*
 Self-checking bench for the floppy controller configuration register bank.
 Assumes one-cycle read/write strobes and read data registered one cycle after the strobe.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, softRst, cfgWrite, cfgRead, cfgHit, drive0_select_n, drive1_select_n;
  logic [7:0] cfgIndex, cfgWdata, cfgRdata;
  logic write_protect_in_n, floppyWpDisable, parallelRoute, coreDensity, coreOutEnable;
  logic coreWriteProtect, densityOut, driveOutEnable, parallelOutEnable, pushPull;
  logic enhanced_os_mode, nonBurstDma, precomp_disable, bootDrive;
  logic [1:0] interfaceMode, drive_type_sel, rate_table_sel;
  logic [7:0] rowIdx [7] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'h10};
  logic [7:0] rowData [7] = '{8'h8e, 8'h0d, 8'h5a, 8'hff, 8'hff, 8'ha4, 8'hff};
  logic [7:0] rowExp [7] = '{8'h8e, 8'h0d, 8'h5a, 8'h00, 8'h5b, 8'h00, 8'h00};
  logic [7:0] rowHit [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
  int n_fail = 0;
  int compares = 0;
  floppy_ctrl_config_regs u_dut (.mclk, .rst, .softRst, .cfgWrite, .cfgRead, .cfgIndex,
    .cfgWdata, .cfgRdata, .cfgHit, .drive0_select_n, .drive1_select_n, .write_protect_in_n,
    .floppyWpDisable, .parallelRoute, .coreDensity, .coreOutEnable, .coreWriteProtect,
    .densityOut, .driveOutEnable, .parallelOutEnable, .pushPull, .enhanced_os_mode,
    .nonBurstDma, .interfaceMode, .drive_type_sel, .rate_table_sel, .precomp_disable,
    .bootDrive);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Stands in for the configuration index/data port decode.
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(negedge mclk);
    cfgIndex = idx;
    cfgWdata = data;
    cfgWrite = 1'b1;
    @(negedge mclk);
    cfgWrite = 1'b0;
  endtask : wr
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    @(negedge mclk);
    cfgIndex = idx;
    cfgRead = 1'b1;
    @(negedge mclk);
    cfgRead = 1'b0;
    chk(what, exp, cfgRdata);
  endtask : rdchk
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // The whole run needs well under a thousand cycles, so this span only cuts a hang.
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {rst, softRst, cfgWrite, cfgRead, cfgIndex, cfgWdata} = {2'b10, 2'b00, 16'h0};
    {drive0_select_n, drive1_select_n, write_protect_in_n, floppyWpDisable} = 4'b1110;
    {parallelRoute, coreDensity, coreOutEnable} = 3'b001;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    rdchk("mode", 8'hf0, 8'h0e);
    rdchk("option", 8'hf1, 8'h00);
    rdchk("type", 8'hf2, 8'hff);
    rdchk("drive0", 8'hf4, 8'h00);
    rdchk("drive1", 8'hf5, 8'h00);
    chk("ifmode", 8'h03, {6'h0, interfaceMode});
    chk("nonburst", 8'h01, {7'h0, nonBurstDma});
    chk("drvoe", 8'h01, {7'h0, driveOutEnable});
    chk("boot", 8'h00, {7'h0, bootDrive});
    $display("Test defaults done");
    for (int i = 0; i < 7; i++) begin
      wr(rowIdx[i], rowData[i]);
      rdchk("readback", rowIdx[i], rowExp[i]);
      chk("hit", rowHit[i], {7'h0, cfgHit});
    end
    $display("Test register rows done");
    for (int m = 0; m < 4; m++) begin
      wr(8'hf0, {4'hc, m[1:0], ~m[0], m[0]});
      chk("ifmode", {6'h0, m[1:0]}, {6'h0, interfaceMode});
      chk("enhanced", {7'h0, m[0]}, {7'h0, enhanced_os_mode});
      chk("nonburst", {7'h0, ~m[0]}, {7'h0, nonBurstDma});
      chk("drvoe", 8'h00, {7'h0, driveOutEnable});
      chk("pushpull", 8'h01, {7'h0, pushPull});
    end
    parallelRoute = 1'b1;
    #1;
    chk("ppoe", 8'h01, {7'h0, parallelOutEnable});
    chk("pushpull", 8'h00, {7'h0, pushPull});
    parallelRoute = 1'b0;
    $display("Test mode fields done");
    wr(8'hf1, 8'h01);
    chk("wp", 8'h00, {7'h0, coreWriteProtect});
    drive1_select_n = 1'b0;
    parallelRoute = 1'b1;
    #1;
    chk("wp", 8'h01, {7'h0, coreWriteProtect});
    {parallelRoute, drive1_select_n, drive0_select_n} = 3'b010;
    #1;
    chk("wp", 8'h01, {7'h0, coreWriteProtect});
    wr(8'hf1, 8'h00);
    chk("wp", 8'h00, {7'h0, coreWriteProtect});
    {write_protect_in_n, floppyWpDisable} = 2'b00;
    #1;
    chk("wp", 8'h01, {7'h0, coreWriteProtect});
    {write_protect_in_n, floppyWpDisable} = 2'b11;
    #1;
    chk("wp", 8'h01, {7'h0, coreWriteProtect});
    floppyWpDisable = 1'b0;
    for (int d = 0; d < 8; d++) begin
      wr(8'hf1, {4'h0, d[2:1], 2'b00});
      coreDensity = d[0];
      #1;
      chk("density", {7'h0, (d[2:1] == 2) | (d[2:1] < 2 & d[0])}, {7'h0, densityOut});
    end
    $display("Test write protect and density done");
    wr(8'hf4, 8'h19);
    wr(8'hf5, 8'h42);
    chk("sel0", 8'h0e, {3'h0, drive_type_sel, rate_table_sel, precomp_disable});
    {drive0_select_n, drive1_select_n} = 2'b10;
    #1;
    chk("sel1", 8'h11, {3'h0, drive_type_sel, rate_table_sel, precomp_disable});
    softRst = 1'b1;
    repeat (2) @(negedge mclk);
    softRst = 1'b0;
    rdchk("drive0", 8'hf4, 8'h19);
    rdchk("type", 8'hf2, 8'h5a);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    rdchk("mode", 8'hf0, 8'h0e);
    rdchk("drive1", 8'hf5, 8'h00);
    rdchk("type", 8'hf2, 8'hff);
    rdchk("drive0", 8'hf4, 8'h00);
    $display("Test drives and resets done");
    tally_and_finish();
  end
endmodule : testbench
